/* File: ssb_defs.svh */
// Constants for the servo status and brake sequencer
`ifndef SSB_DEFS_SVH
`define SSB_DEFS_SVH
`define SSB_MATCH_WIN_RST 16'h0032
`define SSB_REACH_LVL_RST 16'h03E8
`define SSB_HYST 16'h000A
`define SSB_STOP_SPEED 16'h001E
`define SSB_INPOS_RST 19'h0000A
`define SSB_DEN_RST 19'h009C4
`define SSB_LIMIT_RST 2'h1
`define SSB_MS_NS 1000000
`define SSB_CLK_NS 20
`endif

/* File: ssb_pkg.sv */
// Types for the servo status and brake sequencer
package ssb_pkg;
  typedef enum logic [1:0] {SSB_RUN, SSB_HOLD_WAIT, SSB_DECEL, SSB_FREE} ssb_state_t;
endpackage

/* File: ssb_sequencer.sv */
// Servo status outputs, brake sequencing, warning select, pulse divider and limit enables
`timescale 1ns/1ns
`default_nettype none
`include "ssb_defs.svh"
module ssb_sequencer
  import ssb_pkg::*;
#(
  parameter int SPEED_W = 17,
  parameter int MS_CYCLES = `SSB_MS_NS / `SSB_CLK_NS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Motion state: signed speeds in mm/s, two's complement position error
  input wire logic signed [SPEED_W-1:0] motor_speed,
  input wire logic signed [SPEED_W-1:0] speed_command,
  input wire logic [18:0] position_error,
  // Configuration
  input wire logic [15:0] speed_match_window,
  input wire logic [15:0] speed_reached_level,
  input wire logic [13:0] brake_delay_stopped,
  input wire logic [13:0] brake_delay_moving,
  input wire logic [3:0] warn_out_select_a,
  input wire logic [3:0] warn_out_select_b,
  input wire logic [18:0] in_position_window_a,
  input wire logic [18:0] in_position_window_b,
  input wire logic [18:0] pulse_divider_numerator,
  input wire logic [18:0] pulse_divider_denominator,
  input wire logic [1:0] travel_limit_select,
  // Pins and warning sources
  input wire logic run_cmd_in,
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  input wire logic [10:0] warn_src,
  input wire logic enc_pulse,
  // Status outputs
  output logic speed_match_out,
  output logic speed_reached_out,
  output logic brake_hold_out,
  output logic motor_energized,
  output logic decel_req,
  output logic warn_out_a,
  output logic warn_out_b,
  output logic in_pos_a,
  output logic in_pos_b,
  output logic pulse_out,
  output logic fwd_limit_active,
  output logic rev_limit_active,
  output logic prohibit_alarm
);
  // Speed difference needs one bit above the widest command; zero-length millisecond cannot tick
  if (SPEED_W < 17 || MS_CYCLES < 1) begin : g_bad_params
    $error("ssb_sequencer: bad parameters");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Magnitude of a signed speed, returned unsigned at the same width so the negative extreme fits
  function automatic logic [SPEED_W-1:0] mag(input logic signed [SPEED_W-1:0] v);
    mag = v[SPEED_W-1] ? SPEED_W'(-v) : SPEED_W'(v);
  endfunction

  // Hysteretic comparator: on at or above lim, off below lim-HYST
  function automatic logic hyst(input logic cur, input logic [SPEED_W-1:0] val, input logic [15:0] lim);
    if (cur) hyst = (val + SPEED_W'(`SSB_HYST)) >= SPEED_W'(lim);
    else hyst = val >= SPEED_W'(lim);
  endfunction

  // Warning source lookup; unlisted codes give no output
  function automatic logic warn_pick(input logic [3:0] sel, input logic [10:0] src);
    case (sel)
      4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA: warn_pick = src[sel];
      default: warn_pick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Input synchronisers (three stages, agree on last two)
  // ----------------------------------------
  logic [3:0] s1, s2, s3, filt, next_filt;
  wire logic [3:0] pins = {enc_pulse, rev_limit_in, fwd_limit_in, run_cmd_in};
  always_comb begin
    next_filt = filt;
    for (int i = 0; i < 4; i++) begin
      if (s2[i] == s3[i]) next_filt[i] = s3[i];
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {s1, s2, s3, filt} <= 16'h0000;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end
  wire logic run_s = filt[0];
  wire logic fwd_open = filt[1];
  wire logic rev_open = filt[2];
  wire logic enc_s = filt[3];

  // ----------------------------------------
  // Speed comparisons
  // ----------------------------------------
  logic [SPEED_W-1:0] spd_mag, err_mag;
  logic next_match, next_reached, slow;
  always_comb begin
    spd_mag = mag(motor_speed);
    err_mag = mag(SPEED_W'(motor_speed - speed_command));
    // Matching band sits inside window; release needs error 10 above it
    if (speed_match_out) next_match = err_mag < (SPEED_W'(speed_match_window) + SPEED_W'(`SSB_HYST));
    else next_match = err_mag < SPEED_W'(speed_match_window);
    next_reached = hyst(speed_reached_out, spd_mag, speed_reached_level);
    slow = spd_mag <= SPEED_W'(`SSB_STOP_SPEED);
  end

  // ----------------------------------------
  // Brake sequencer
  // ----------------------------------------
  ssb_state_t state, next_state;
  logic [13:0] ms_cnt, next_ms_cnt;
  logic [$clog2(MS_CYCLES+1)-1:0] tick_cnt, next_tick_cnt;
  logic next_brake, next_energized, next_decel, tick;
  always_comb begin
    tick = tick_cnt == ($bits(tick_cnt))'(MS_CYCLES - 1);
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    next_state = state;
    next_ms_cnt = ms_cnt;
    next_brake = brake_hold_out;
    next_energized = motor_energized;
    next_decel = 1'b0;
    unique case (state)
      SSB_RUN: begin
        next_brake = 1'b0;
        next_energized = 1'b1;
        next_ms_cnt = 14'h0000;
        next_tick_cnt = '0;
        if (!run_s) begin
          if (slow) begin
            next_brake = 1'b1;
            next_state = SSB_HOLD_WAIT;
          end else begin
            next_decel = 1'b1;
            next_state = SSB_DECEL;
          end
        end
      end
      SSB_HOLD_WAIT: begin
        // Motor stays energised until brake has had time to bite
        if (ms_cnt >= brake_delay_stopped) begin
          next_energized = 1'b0;
          next_state = SSB_FREE;
        end else if (tick) next_ms_cnt = ms_cnt + 14'h0001;
      end
      SSB_DECEL: begin
        next_decel = 1'b1;
        // Earlier of delay expiry or low speed
        if (ms_cnt >= brake_delay_moving || slow) begin
          next_brake = 1'b1;
          next_energized = 1'b0;
          next_decel = 1'b0;
          next_state = SSB_FREE;
        end else if (tick) next_ms_cnt = ms_cnt + 14'h0001;
      end
      SSB_FREE: begin
        if (run_s) next_state = SSB_RUN;
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= SSB_FREE;
      ms_cnt <= 14'h0000;
      tick_cnt <= '0;
      brake_hold_out <= 1'b1;
      motor_energized <= 1'b0;
      decel_req <= 1'b0;
    end else begin
      state <= next_state;
      ms_cnt <= next_ms_cnt;
      tick_cnt <= next_tick_cnt;
      brake_hold_out <= next_brake;
      motor_energized <= next_energized;
      decel_req <= next_decel;
    end
  end

  // ----------------------------------------
  // Pulse divider: accumulate numerator, emit when denominator reached
  // ----------------------------------------
  logic [19:0] acc, next_acc;
  logic enc_d, next_pulse;
  wire logic enc_rise = enc_s && !enc_d;
  logic [18:0] num_eff, den_eff;
  always_comb begin
    den_eff = (pulse_divider_denominator == 19'h00000) ? 19'h00001 : pulse_divider_denominator;
    // Clamping ratio to one keeps output at most encoder rate
    num_eff = (pulse_divider_numerator > den_eff) ? den_eff : pulse_divider_numerator;
    next_acc = acc;
    next_pulse = 1'b0;
    if (enc_rise) begin
      next_acc = acc + {1'b0, num_eff};
      if (next_acc >= {1'b0, den_eff}) begin
        next_acc = next_acc - {1'b0, den_eff};
        next_pulse = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {acc, enc_d, pulse_out} <= 22'h00000;
    end else begin
      acc <= next_acc;
      enc_d <= enc_s;
      pulse_out <= next_pulse;
    end
  end

  // ----------------------------------------
  // Status outputs, warnings, in-position, limits
  // ----------------------------------------
  logic [18:0] perr_mag;
  logic lim_en, next_alarm, next_warn_a, next_warn_b, next_in_pos_a, next_in_pos_b, next_fwd, next_rev;
  always_comb begin
    perr_mag = position_error[18] ? 19'(-position_error) : position_error;
    lim_en = (travel_limit_select == 2'h0) || (travel_limit_select == 2'h2);
    next_warn_a = warn_pick(warn_out_select_a, warn_src);
    next_warn_b = warn_pick(warn_out_select_b, warn_src);
    next_in_pos_a = perr_mag <= in_position_window_a;
    next_in_pos_b = perr_mag <= in_position_window_b;
    next_fwd = lim_en && fwd_open;
    next_rev = lim_en && rev_open;
    if (travel_limit_select == 2'h2) next_alarm = fwd_open || rev_open;
    else if (travel_limit_select == 2'h0) next_alarm = fwd_open && rev_open;
    else next_alarm = 1'b0;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {speed_match_out, speed_reached_out, warn_out_a, warn_out_b, in_pos_a} <= 5'h00;
      {in_pos_b, fwd_limit_active, rev_limit_active, prohibit_alarm} <= 4'h0;
    end else begin
      speed_match_out <= next_match;
      speed_reached_out <= next_reached;
      warn_out_a <= next_warn_a;
      warn_out_b <= next_warn_b;
      in_pos_a <= next_in_pos_a;
      in_pos_b <= next_in_pos_b;
      fwd_limit_active <= next_fwd;
      rev_limit_active <= next_rev;
      prohibit_alarm <= next_alarm;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_brake_stopped: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == SSB_RUN && !run_s && slow) |=> brake_hold_out && motor_energized)
    else $error("brake not held at once on stopped run drop");
  a_decel_no_brake: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == SSB_RUN && !run_s && !slow) |=> !brake_hold_out && decel_req)
    else $error("brake applied early when moving");
  a_slow_brake: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == SSB_DECEL && slow) |=> brake_hold_out && !motor_energized)
    else $error("brake late at low speed");
  a_reach_hyst: assert property (@(posedge core_clk) disable iff (!reset_n)
    (speed_reached_out && spd_mag + SPEED_W'(`SSB_HYST) >= SPEED_W'(speed_reached_level)) |=> speed_reached_out)
    else $error("speed reached released inside hysteresis");
  a_match_on: assert property (@(posedge core_clk) disable iff (!reset_n)
    (err_mag < SPEED_W'(speed_match_window)) |=> speed_match_out)
    else $error("speed match missing");
  a_warn_b: assert property (@(posedge core_clk) disable iff (!reset_n)
    (warn_out_select_b == 4'h1 && warn_src[1]) |=> warn_out_b)
    else $error("warning b not mapped");
  a_limit_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    (travel_limit_select == 2'h1) |=> !fwd_limit_active && !rev_limit_active && !prohibit_alarm)
    else $error("limits not disabled");
  a_pulse_rate: assert property (@(posedge core_clk) disable iff (!reset_n)
    pulse_out |-> $past(enc_rise))
    else $error("pulse without encoder edge");
endmodule
`default_nettype wire

/* File: ssb_host_model.sv */
// Host-side model that counts the divided encoder pulses
`timescale 1ns/1ns
`default_nettype none
module ssb_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Divided pulse from the drive
  input wire logic pulse_out,
  // Running count for the bench
  output var int pulse_count
);
  int next_pulse_count;
  // A pulse lasts one cycle, so a plain sample counts it once with no edge detect
  always_comb begin
    next_pulse_count = pulse_count + (pulse_out ? 1 : 0);
  end
  // Count register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_count <= 0;
    end else begin
      pulse_count <= next_pulse_count;
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the servo status and brake sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ssb_pkg::*;
  logic core_clk = 0, reset_n = 0, run_cmd_in = 0, fwd_limit_in = 0, rev_limit_in = 0, enc_pulse = 0;
  logic signed [16:0] motor_speed = 0, speed_command = 0;
  logic [18:0] position_error = 0, in_position_window_a = 19'h0000A, in_position_window_b = 19'h00003;
  logic [18:0] pulse_divider_numerator = 19'h00001, pulse_divider_denominator = 19'h00003;
  logic [15:0] speed_match_window = 16'h0032, speed_reached_level = 16'h03E8;
  logic [13:0] brake_delay_stopped = 14'h0002, brake_delay_moving = 14'h0003;
  logic [3:0] warn_out_select_a = 0, warn_out_select_b = 0;
  logic [1:0] travel_limit_select = 2'h1;
  logic [10:0] warn_src = 0;
  logic speed_match_out, speed_reached_out, brake_hold_out, motor_energized, decel_req, warn_out_a;
  logic warn_out_b, in_pos_a, in_pos_b, pulse_out, fwd_limit_active, rev_limit_active, prohibit_alarm;
  logic [11:0] obs;
  logic [23:0] exp_q[$];
  logic [23:0] e;
  logic [3:0] codes[9] = '{0, 1, 2, 4, 5, 7, 8, 9, 10};
  int pulse_count, base, c, k, num_errors = 0, n_checks = 0, seed = 32'hf8c8;
  event smp;
  assign obs = {speed_match_out, speed_reached_out, brake_hold_out, motor_energized, decel_req, warn_out_a,
                warn_out_b, in_pos_a, in_pos_b, fwd_limit_active, rev_limit_active, prohibit_alarm};
  // Short millisecond keeps the brake waits to a few cycles
  ssb_sequencer #(.SPEED_W(17), .MS_CYCLES(4)) uut (.core_clk, .reset_n, .motor_speed, .speed_command,
    .position_error, .speed_match_window, .speed_reached_level, .brake_delay_stopped, .brake_delay_moving,
    .warn_out_select_a, .warn_out_select_b, .in_position_window_a, .in_position_window_b,
    .pulse_divider_numerator, .pulse_divider_denominator, .travel_limit_select, .run_cmd_in, .fwd_limit_in,
    .rev_limit_in, .warn_src, .enc_pulse, .speed_match_out, .speed_reached_out, .brake_hold_out,
    .motor_energized, .decel_req, .warn_out_a, .warn_out_b, .in_pos_a, .in_pos_b, .pulse_out,
    .fwd_limit_active, .rev_limit_active, .prohibit_alarm);
  ssb_host_model host (.core_clk, .reset_n, .pulse_out, .pulse_count);
  initial forever #10 core_clk = ~core_clk;
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Notes are taken off the edge so outputs have settled; the next drive lands on an edge again
  task note(input logic [11:0] m, input logic [11:0] v);
    #2;
    exp_q.push_back({m, v & m});
    -> smp;
    @(posedge core_clk);
  endtask
  initial forever begin
    @(smp);
    e = exp_q.pop_front();
    check(obs & e[23:12], e[11:0]);
  end
  task await(input int i, input logic v, input int lim);
    c = 0;
    #2;
    while (obs[i] !== v) begin
      if (c == lim) begin
        num_errors++;
        $display("Error at %0t: wait expired", $time);
        summarize();
      end
      @(posedge core_clk);
      #2;
      c++;
    end
    @(posedge core_clk);
  endtask
  task sp(input int s, input logic [11:0] m, input logic [11:0] v);
    motor_speed <= s[16:0];
    cyc(3);
    note(m, v);
  endtask
  task encs(input int n);
    repeat (n) begin
      enc_pulse <= 1;
      cyc(5);
      enc_pulse <= 0;
      cyc(5);
    end
  endtask
  task done(input string s);
    $display("Test %s finished", s);
  endtask
  task summarize;
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(19);
    note(12'hFFF, 12'h200);
    reset_n <= 1;
    run_cmd_in <= 1;
    speed_command <= 17'sd500;
    sp(520, 12'h800, 12'h800);
    sp(555, 12'h800, 12'h800);
    sp(560, 12'h800, 12'h000);
    sp(-1000, 12'h400, 12'h400);
    sp(-991, 12'h400, 12'h400);
    sp(989, 12'h400, 12'h000);
    done("speed");
    for (k = 0; k < 9; k++) begin
      warn_src <= 11'($random(seed));
      warn_out_select_a <= codes[k]; // Listed codes plus unlisted code 0
      warn_out_select_b <= codes[8 - k];
      cyc(6);
      note(12'h060, {5'h0, k != 0 && warn_src[codes[k]], k != 8 && warn_src[codes[8 - k]], 5'h0});
    end
    position_error <= -19'sd5;
    cyc(3);
    note(12'h018, 12'h010);
    for (k = 0; k < 12; k++) begin
      travel_limit_select <= 2'(k / 4);
      {fwd_limit_in, rev_limit_in} <= k[1:0];
      cyc(6);
      note(12'h007, {9'h0, k / 4 != 1 && k[1], k / 4 != 1 && k[0],
                     k / 4 == 2 ? k % 4 != 0 : k == 3});
    end
    done("status");
    sp(0, 12'h100, 12'h100);
    run_cmd_in <= 0;
    await(9, 1, 10);
    note(12'h380, 12'h300);
    await(8, 0, 20);
    check(c inside {[5:9]}, 1);
    run_cmd_in <= 1;
    // Run level needs the synchroniser and one state step before the drive is back in run
    cyc(4);
    sp(500, 12'h380, 12'h100);
    run_cmd_in <= 0;
    await(7, 1, 10);
    note(12'h300, 12'h100);
    await(9, 1, 30);
    check(c inside {[8:14]}, 1);
    run_cmd_in <= 1;
    brake_delay_moving <= 14'h0064;
    cyc(10);
    run_cmd_in <= 0;
    await(7, 1, 10);
    note(12'h380, 12'h180);
    sp(30, 12'h380, 12'h200);
    await(9, 1, 4);
    note(12'h380, 12'h200);
    done("brake");
    base = pulse_count;
    encs(9);
    check(pulse_count - base, 3);
    pulse_divider_numerator <= 19'h00005;
    pulse_divider_denominator <= 19'h00002;
    base = pulse_count;
    encs(9);
    check(pulse_count - base, 9);
    done("divider");
    summarize();
  end
endmodule
`default_nettype wire
